// >>> ocd_consts.vh
`ifndef OCD_CONSTS_VH
`define OCD_CONSTS_VH

// ****************************************
// register indices (byte address = 4 * index)
// ****************************************
`define OCD_IDX_DIV1_COUNTS 12'h193
`define OCD_IDX_DIV1_CTRL 12'h194
`define OCD_IDX_DIV1_ROUTE 12'h195
`define OCD_IDX_DIV2_COUNTS 12'h196
`define OCD_IDX_DIV2_CTRL 12'h197
`define OCD_IDX_DIV2_ROUTE 12'h198
`define OCD_IDX_S31_COUNTS 12'h199
`define OCD_IDX_S3_PHASE 12'h19a
`define OCD_IDX_S32_COUNTS 12'h19b
`define OCD_IDX_S3_BYPASS 12'h19c
`define OCD_IDX_SRC_SEL 12'h1e1
`define OCD_IDX_STATUS 12'h1e2

// ****************************************
// field positions
// ****************************************
`define OCD_F_LOW_HI 7
`define OCD_F_LOW_LO 4
`define OCD_F_HIGH_HI 3
`define OCD_F_HIGH_LO 0
`define OCD_F_BYPASS 7
`define OCD_F_NOSYNC 6
`define OCD_F_FORCE_HIGH 5
`define OCD_F_START_HIGH 4
`define OCD_F_PHASE_HI 3
`define OCD_F_PHASE_LO 0
`define OCD_F_DIRECT 1
`define OCD_F_DCC_OFF 0
`define OCD_F_S32_BYPASS 5
`define OCD_F_S31_BYPASS 4

// ****************************************
// reset values
// ****************************************
`define OCD_RST_COUNTS 8'h00
`define OCD_RST_DIV1_CTRL 8'h00
`define OCD_RST_DIV2_CTRL 8'h80
`define OCD_RST_ROUTE 8'h00
`define OCD_RST_PHASE 8'h00
`define OCD_RST_S3_BYPASS 8'h00
`define OCD_RST_SRC_SEL 2'h0

// ****************************************
// source select codes
// ****************************************
`define OCD_SRC_EXT 2'h0
`define OCD_SRC_NONE 2'h1
`define OCD_SRC_OSC 2'h2

// ****************************************
// timing: oscillator model half period
// ****************************************
`define OCD_OSC_HALF_NS 20
`define OCD_CLK_PERIOD_NS 10
`define OCD_OSC_HALF_CYC ((`OCD_OSC_HALF_NS + `OCD_CLK_PERIOD_NS - 1) / `OCD_CLK_PERIOD_NS)

`endif

// >>> ocd_div.v
`include "ocd_consts.vh"

module ocd_div #(
    parameter CW = 4
) (
    // clock and reset
    input wire clk_i,
    input wire rst_i,
    // divider input clock
    input wire in_lvl_i,
    input wire tick_i,
    // setup
    input wire [CW-1:0] low_i,
    input wire [CW-1:0] high_i,
    input wire [CW-1:0] phase_i,
    input wire bypass_i,
    input wire start_high_i,
    input wire hold_i,
    input wire hold_level_i,
    input wire dcc_off_i,
    // output
    output reg out_o
);

    reg [CW-1:0] cnt_q;
    reg [CW-1:0] phs_q;
    reg pend_q;
    reg lvl_q;
    reg fell_q;
    reg out_d;
    wire odd_total;

    // an odd total ratio cannot split evenly; correction lends half an input cycle to high
    assign odd_total = low_i[0] ^ high_i[0];

    // ****************************************
    // counting
    // ****************************************
    always @(posedge clk_i) begin
        if (rst_i) begin
            cnt_q <= {CW{1'b0}};
            phs_q <= {CW{1'b0}};
            pend_q <= 1'b1;
            lvl_q <= 1'b0;
            fell_q <= 1'b0;
        end else if (hold_i) begin
            cnt_q <= {CW{1'b0}};
            phs_q <= {CW{1'b0}};
            pend_q <= 1'b1;
            lvl_q <= hold_level_i;
            fell_q <= 1'b0;
        end else if (tick_i && !bypass_i) begin
            fell_q <= 1'b0;
            if (pend_q) begin
                if (phs_q == phase_i) begin
                    pend_q <= 1'b0;
                    lvl_q <= start_high_i;
                    cnt_q <= {CW{1'b0}};
                end else begin
                    phs_q <= phs_q + 1'b1;
                end
            end else if (cnt_q == (lvl_q ? high_i : low_i)) begin
                lvl_q <= ~lvl_q;
                fell_q <= lvl_q;
                cnt_q <= {CW{1'b0}};
            end else begin
                cnt_q <= cnt_q + 1'b1;
            end
        end
    end

    // ****************************************
    // output selection
    // ****************************************
    always @* begin
        if (hold_i) begin
            out_d = hold_level_i;
        end else if (bypass_i) begin
            out_d = in_lvl_i;
        end else if (!dcc_off_i && odd_total) begin
            out_d = lvl_q | (fell_q & in_lvl_i);
        end else begin
            out_d = lvl_q;
        end
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            out_o <= 1'b0;
        end else begin
            out_o <= out_d;
        end
    end

endmodule // ocd_div

// >>> ocd_top.v
// Summary of operation
// - divider output stays low for low count plus one input cycles.
// - divider output stays high for high count plus one input cycles.
// - bypass bit passes input clock to output; divider 2 resets bypassed.
// - sync-ignore clear obeys chip sync; set ignores it.
// - while synchronising, output sits at the force-high level.
// - output begins at the start-level bit value.
// - each channel divider delays its start by its phase field.
// - direct-route picks oscillator at 10b, external at 00b, divider otherwise.
// - duty correction applies while its disable bit is zero.
// - divider 1 feeds pair 2, divider 2 feeds pair 3.
// - stage 3.1 holds low then high for counts plus one.
// - stage 3.2 holds low then high for counts plus one.
// - stage 3.1 phase is low nibble, stage 3.2 phase high nibble.
// - each stage has its own bypass bit, clear after reset.
//
// Added by the designer: the Wishbone interface to the registers.
`include "ocd_consts.vh"

module ocd_top #(
    parameter CW = 4,
    parameter OSC_HALF = `OCD_OSC_HALF_CYC
) (
    // clock and reset
    input wire clk_i,
    input wire rst_i,
    // wishbone slave
    input wire cyc_i,
    input wire stb_i,
    input wire we_i,
    input wire [11:0] adr_i,
    input wire [3:0] sel_i,
    input wire [31:0] dat_i,
    output reg [31:0] dat_o,
    output reg ack_o,
    // pins
    input wire ext_clk_i,
    input wire sync_i,
    // clock outputs
    output reg pair2_output_a_o,
    output reg pair2_output_b_o,
    output reg pair3_output_a_o,
    output reg pair3_output_b_o,
    output wire stage3_output_o
);

    // ****************************************
    // registers
    // ****************************************
    reg [7:0] div1_counts_q;
    reg [7:0] div1_ctrl_q;
    reg [7:0] div1_route_dcc_q;
    reg [7:0] div2_counts_q;
    reg [7:0] div2_ctrl_q;
    reg [7:0] div2_route_dcc_q;
    reg [7:0] stage31_counts_q;
    reg [7:0] stage3_phase_q;
    reg [7:0] stage32_counts_q;
    reg [7:0] stage3_bypass_q;
    reg [1:0] global_source_select_q;
    wire [11:0] idx;
    wire wr_go;
    reg [7:0] rd_d;

    // ****************************************
    // input synchronisers and source clock
    // ****************************************
    reg ext_m_q;
    reg ext_s_q;
    reg sync_m_q;
    reg sync_s_q;
    reg osc_lvl_q;
    reg [15:0] osc_cnt_q;
    reg src_prev_q;
    reg s31_prev_q;
    wire src_lvl;
    wire src_tick;
    wire s31_out;
    wire s31_tick;
    wire div1_out;
    wire div2_out;
    wire div1_hold;
    wire div2_hold;

    always @(posedge clk_i) begin
        if (rst_i) begin
            ext_m_q <= 1'b0;
            ext_s_q <= 1'b0;
            sync_m_q <= 1'b0;
            sync_s_q <= 1'b0;
        end else begin
            ext_m_q <= ext_clk_i;
            ext_s_q <= ext_m_q;
            sync_m_q <= sync_i;
            sync_s_q <= sync_m_q;
        end
    end

    // oscillator stand-in: a square wave from a divider on the system clock
    always @(posedge clk_i) begin
        if (rst_i) begin
            osc_cnt_q <= 16'h0000;
            osc_lvl_q <= 1'b0;
        end else if (osc_cnt_q == OSC_HALF[15:0] - 16'h0001) begin
            osc_cnt_q <= 16'h0000;
            osc_lvl_q <= ~osc_lvl_q;
        end else begin
            osc_cnt_q <= osc_cnt_q + 16'h0001;
        end
    end

    // distribution clock: oscillator when select bit 1 is set, else external input
    assign src_lvl = global_source_select_q[1] ? osc_lvl_q : ext_s_q;
    assign src_tick = src_lvl & ~src_prev_q;

    always @(posedge clk_i) begin
        if (rst_i) begin
            src_prev_q <= 1'b0;
            s31_prev_q <= 1'b0;
        end else begin
            src_prev_q <= src_lvl;
            s31_prev_q <= s31_out;
        end
    end

    // ****************************************
    // channel dividers
    // ****************************************
    assign div1_hold = sync_s_q & ~div1_ctrl_q[`OCD_F_NOSYNC];
    assign div2_hold = sync_s_q & ~div2_ctrl_q[`OCD_F_NOSYNC];

    ocd_div #(.CW(CW)) u_div1 (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .in_lvl_i(src_lvl),
        .tick_i(src_tick),
        .low_i(div1_counts_q[`OCD_F_LOW_HI:`OCD_F_LOW_LO]),
        .high_i(div1_counts_q[`OCD_F_HIGH_HI:`OCD_F_HIGH_LO]),
        .phase_i(div1_ctrl_q[`OCD_F_PHASE_HI:`OCD_F_PHASE_LO]),
        .bypass_i(div1_ctrl_q[`OCD_F_BYPASS]),
        .start_high_i(div1_ctrl_q[`OCD_F_START_HIGH]),
        .hold_i(div1_hold),
        .hold_level_i(div1_ctrl_q[`OCD_F_FORCE_HIGH]),
        .dcc_off_i(div1_route_dcc_q[`OCD_F_DCC_OFF]),
        .out_o(div1_out)
    );

    ocd_div #(.CW(CW)) u_div2 (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .in_lvl_i(src_lvl),
        .tick_i(src_tick),
        .low_i(div2_counts_q[`OCD_F_LOW_HI:`OCD_F_LOW_LO]),
        .high_i(div2_counts_q[`OCD_F_HIGH_HI:`OCD_F_HIGH_LO]),
        .phase_i(div2_ctrl_q[`OCD_F_PHASE_HI:`OCD_F_PHASE_LO]),
        .bypass_i(div2_ctrl_q[`OCD_F_BYPASS]),
        .start_high_i(div2_ctrl_q[`OCD_F_START_HIGH]),
        .hold_i(div2_hold),
        .hold_level_i(div2_ctrl_q[`OCD_F_FORCE_HIGH]),
        .dcc_off_i(div2_route_dcc_q[`OCD_F_DCC_OFF]),
        .out_o(div2_out)
    );

    // ****************************************
    // low-voltage channel cascade
    // ****************************************
    // stage controls beyond counts, phase and bypass are outside this block:
    // the stages always obey sync, start low and hold low during it
    assign s31_tick = s31_out & ~s31_prev_q;

    ocd_div #(.CW(CW)) u_s31 (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .in_lvl_i(src_lvl),
        .tick_i(src_tick),
        .low_i(stage31_counts_q[`OCD_F_LOW_HI:`OCD_F_LOW_LO]),
        .high_i(stage31_counts_q[`OCD_F_HIGH_HI:`OCD_F_HIGH_LO]),
        .phase_i(stage3_phase_q[3:0]),
        .bypass_i(stage3_bypass_q[`OCD_F_S31_BYPASS]),
        .start_high_i(1'b0),
        .hold_i(sync_s_q),
        .hold_level_i(1'b0),
        .dcc_off_i(1'b1),
        .out_o(s31_out)
    );

    ocd_div #(.CW(CW)) u_s32 (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .in_lvl_i(s31_out),
        .tick_i(s31_tick),
        .low_i(stage32_counts_q[`OCD_F_LOW_HI:`OCD_F_LOW_LO]),
        .high_i(stage32_counts_q[`OCD_F_HIGH_HI:`OCD_F_HIGH_LO]),
        .phase_i(stage3_phase_q[7:4]),
        .bypass_i(stage3_bypass_q[`OCD_F_S32_BYPASS]),
        .start_high_i(1'b0),
        .hold_i(sync_s_q),
        .hold_level_i(1'b0),
        .dcc_off_i(1'b1),
        .out_o(stage3_output_o)
    );

    // ****************************************
    // output pair routing
    // ****************************************
    function route_sel;
        input direct;
        input [1:0] src;
        input div_lvl;
        input osc_lvl;
        input ext_lvl;
        begin
            route_sel = div_lvl;
            if (direct && src == `OCD_SRC_OSC) begin
                route_sel = osc_lvl;
            end else if (direct && src == `OCD_SRC_EXT) begin
                route_sel = ext_lvl;
            end
        end
    endfunction

    always @(posedge clk_i) begin
        if (rst_i) begin
            pair2_output_a_o <= 1'b0;
            pair2_output_b_o <= 1'b1;
            pair3_output_a_o <= 1'b0;
            pair3_output_b_o <= 1'b1;
        end else begin
            pair2_output_a_o <= route_sel(div1_route_dcc_q[`OCD_F_DIRECT],
                global_source_select_q, div1_out, osc_lvl_q, ext_s_q);
            pair2_output_b_o <= ~route_sel(div1_route_dcc_q[`OCD_F_DIRECT],
                global_source_select_q, div1_out, osc_lvl_q, ext_s_q);
            pair3_output_a_o <= route_sel(div2_route_dcc_q[`OCD_F_DIRECT],
                global_source_select_q, div2_out, osc_lvl_q, ext_s_q);
            pair3_output_b_o <= ~route_sel(div2_route_dcc_q[`OCD_F_DIRECT],
                global_source_select_q, div2_out, osc_lvl_q, ext_s_q);
        end
    end

    // ****************************************
    // wishbone slave
    // ****************************************
    // one wait state: ack rises the edge after the request, and a write lands at the
    // edge that samples ack high, so master and slave agree on when it took effect
    assign idx = {2'h0, adr_i[11:2]};
    assign wr_go = cyc_i & stb_i & we_i & ack_o & sel_i[0];

    always @* begin
        case (idx)
            `OCD_IDX_DIV1_COUNTS: rd_d = div1_counts_q;
            `OCD_IDX_DIV1_CTRL: rd_d = div1_ctrl_q;
            `OCD_IDX_DIV1_ROUTE: rd_d = div1_route_dcc_q;
            `OCD_IDX_DIV2_COUNTS: rd_d = div2_counts_q;
            `OCD_IDX_DIV2_CTRL: rd_d = div2_ctrl_q;
            `OCD_IDX_DIV2_ROUTE: rd_d = div2_route_dcc_q;
            `OCD_IDX_S31_COUNTS: rd_d = stage31_counts_q;
            `OCD_IDX_S3_PHASE: rd_d = stage3_phase_q;
            `OCD_IDX_S32_COUNTS: rd_d = stage32_counts_q;
            `OCD_IDX_S3_BYPASS: rd_d = stage3_bypass_q;
            `OCD_IDX_SRC_SEL: rd_d = {6'h00, global_source_select_q};
            `OCD_IDX_STATUS: rd_d = {4'h0, sync_s_q, stage3_output_o,
                pair3_output_a_o, pair2_output_a_o};
            default: rd_d = 8'h00;
        endcase
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            dat_o <= 32'h00000000;
        end else begin
            ack_o <= cyc_i & stb_i & ~ack_o;
            dat_o <= {24'h000000, rd_d};
        end
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            div1_counts_q <= `OCD_RST_COUNTS;
            div1_ctrl_q <= `OCD_RST_DIV1_CTRL;
            div1_route_dcc_q <= `OCD_RST_ROUTE;
            div2_counts_q <= `OCD_RST_COUNTS;
            div2_ctrl_q <= `OCD_RST_DIV2_CTRL;
            div2_route_dcc_q <= `OCD_RST_ROUTE;
            stage31_counts_q <= `OCD_RST_COUNTS;
            stage3_phase_q <= `OCD_RST_PHASE;
            stage32_counts_q <= `OCD_RST_COUNTS;
            stage3_bypass_q <= `OCD_RST_S3_BYPASS;
            global_source_select_q <= `OCD_RST_SRC_SEL;
        end else if (wr_go) begin
            case (idx)
                `OCD_IDX_DIV1_COUNTS: div1_counts_q <= dat_i[7:0];
                `OCD_IDX_DIV1_CTRL: div1_ctrl_q <= dat_i[7:0];
                `OCD_IDX_DIV1_ROUTE: div1_route_dcc_q <= {6'h00, dat_i[1:0]};
                `OCD_IDX_DIV2_COUNTS: div2_counts_q <= dat_i[7:0];
                `OCD_IDX_DIV2_CTRL: div2_ctrl_q <= dat_i[7:0];
                `OCD_IDX_DIV2_ROUTE: div2_route_dcc_q <= {6'h00, dat_i[1:0]};
                `OCD_IDX_S31_COUNTS: stage31_counts_q <= dat_i[7:0];
                `OCD_IDX_S3_PHASE: stage3_phase_q <= dat_i[7:0];
                `OCD_IDX_S32_COUNTS: stage32_counts_q <= dat_i[7:0];
                `OCD_IDX_S3_BYPASS: stage3_bypass_q <= {2'h0, dat_i[5:4], 4'h0};
                `OCD_IDX_SRC_SEL: global_source_select_q <= dat_i[1:0];
                default: ;
            endcase
        end
    end

endmodule // ocd_top

// >>> ocd_top_chk.sv
`include "ocd_consts.vh"

module ocd_top_chk (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // register bus
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [11:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    input wire logic [31:0] dat_o,
    input wire logic ack_o,
    // pins
    input wire logic sync_i,
    input wire logic pair2_output_a_o,
    input wire logic pair2_output_b_o,
    input wire logic pair3_output_a_o,
    input wire logic pair3_output_b_o,
    input wire logic stage3_output_o
);
    // ****
    // shadow of divider 1 control
    // ****
    logic [7:0] ctrl1_q;
    logic [3:0] quiet_q;
    // a write lands at the edge that samples ack high
    wire take = cyc_i & stb_i & ack_o;

    // quiet_q masks the few cycles a fresh control write needs to reach the pins
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl1_q <= 8'h00;
            quiet_q <= 4'h0;
        end else begin
            if (take && we_i && sel_i[0] && {2'h0, adr_i[11:2]} == `OCD_IDX_DIV1_CTRL) begin
                ctrl1_q <= dat_i[7:0];
            end
            if (take && we_i) begin
                quiet_q <= 4'h0;
            end else if (quiet_q != 4'hf) begin
                quiet_q <= quiet_q + 4'h1;
            end
        end
    end

    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence bus_req;
        cyc_i && stb_i && !ack_o;
    endsequence
    sequence sync_held;
        sync_i [*6];
    endsequence

    a_ack_answer: assert property (bus_req |=> ack_o)
        else $error("no ack one cycle after request");
    a_ack_pulse: assert property (ack_o |=> !ack_o)
        else $error("ack longer than one cycle");
    a_read_upper: assert property (ack_o |-> dat_o[31:8] == 24'h0)
        else $error("read data upper bits not zero");
    a_pair2_compl: assert property (pair2_output_b_o == !pair2_output_a_o)
        else $error("pair 2 outputs not complementary");
    a_pair3_compl: assert property (pair3_output_b_o == !pair3_output_a_o)
        else $error("pair 3 outputs not complementary");
    a_force_level: assert property (sync_held ##0 (quiet_q > 4'h5 && ctrl1_q[7:6] == 2'h0)
        |-> pair2_output_a_o == ctrl1_q[5])
        else $error("pair 2 not at forced level during sync");
    a_stage3_sync: assert property (sync_held |-> !stage3_output_o)
        else $error("stage 3 output not low during sync");
    a_reset_state: assert property ($fell(rst_i) |-> !ack_o && dat_o == 32'h0 && !pair2_output_a_o
        && pair2_output_b_o && !pair3_output_a_o && pair3_output_b_o && !stage3_output_o)
        else $error("outputs not at reset values");
endmodule // ocd_top_chk

bind ocd_top ocd_top_chk u_chk (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .sync_i(sync_i), .pair2_output_a_o(pair2_output_a_o), .pair2_output_b_o(pair2_output_b_o),
    .pair3_output_a_o(pair3_output_a_o), .pair3_output_b_o(pair3_output_b_o),
    .stage3_output_o(stage3_output_o));

// >>> ocd_top_test.sv
`include "ocd_consts.vh"

module ocd_top_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, ext_clk_i = 0, sync_i = 0;
    logic [11:0] adr_i = 0;
    logic [3:0] sel_i = 0;
    logic [31:0] dat_i = 0;
    logic [2:0] ext_cnt = 0;
    wire [31:0] dat_o;
    wire ack_o, p2a, p2b, p3a, p3b, s3;
    int miscompares = 0, compares = 0;

    always #5 clk_i = ~clk_i;
    // external clock of eight system cycles, so one input cycle is 8 clk;
    // a bypassed or direct path therefore shows 4 clk high and 4 clk low
    always @(posedge clk_i) begin
        ext_cnt <= ext_cnt + 3'h1;
        ext_clk_i <= ext_cnt[2];
    end

    ocd_top #(.CW(4), .OSC_HALF(2)) dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
        .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
        .ack_o(ack_o), .ext_clk_i(ext_clk_i), .sync_i(sync_i), .pair2_output_a_o(p2a),
        .pair2_output_b_o(p2b), .pair3_output_a_o(p3a), .pair3_output_b_o(p3b),
        .stage3_output_o(s3));

    // ****
    // checks and bus access
    // ****
    task automatic report_and_stop;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED %0t register got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_int(input int got, input int exp);
        compares++;
        if (got != exp) begin
            miscompares++;
            $display("CHECK FAILED %0t cycles got %0d expected %0d", $time, got, exp);
        end
    endtask

    task automatic wb(input logic w, input logic [11:0] idx, input logic [7:0] d,
        input logic [3:0] s, output logic [7:0] q);
        @(posedge clk_i);
        cyc_i <= 1'h1;
        stb_i <= 1'h1;
        we_i <= w;
        adr_i <= {idx[9:0], 2'h0};
        sel_i <= s;
        dat_i <= {24'h0, d};
        do @(posedge clk_i); while (ack_o !== 1'h1);
        q = dat_o[7:0];
        cyc_i <= 1'h0;
        stb_i <= 1'h0;
    endtask

    task automatic wr(input logic [11:0] idx, input logic [7:0] d);
        logic [7:0] q;
        wb(1'h1, idx, d, 4'h1, q);
    endtask

    task automatic rchk(input logic [11:0] idx, input logic [7:0] exp);
        logic [7:0] q;
        wb(1'h0, idx, 8'h00, 4'h1, q);
        chk_reg(q, exp);
    endtask

    // ****
    // output timing
    // ****
    function automatic logic pick(input int sel);
        return sel == 0 ? p2a : (sel == 1 ? p3a : s3);
    endfunction

    // counts clk cycles while the output stays at v, giving up at 600
    task automatic run_len(input int sel, input logic v, output int n);
        n = 0;
        while (pick(sel) === v && n < 600) begin
            @(posedge clk_i);
            n++;
        end
    endtask

    // skips two periods so a fresh setting has settled
    task automatic measure(input int sel, output int h, output int l);
        int d;
        repeat (2) begin
            run_len(sel, 1'h1, d);
            run_len(sel, 1'h0, d);
        end
        run_len(sel, 1'h1, h);
        run_len(sel, 1'h0, l);
    endtask

    task automatic mchk(input int sel, input int eh, input int el);
        int h, l;
        measure(sel, h, l);
        chk_int(h, eh);
        chk_int(l, el);
    endtask

    // released on a fixed external clock phase so the delays compare exactly
    task automatic t_start(input logic [7:0] c, output int n);
        wr(`OCD_IDX_DIV1_CTRL, c);
        @(posedge clk_i);
        sync_i <= 1'h1;
        repeat (20) @(posedge clk_i);
        while (ext_cnt !== 3'h7) @(posedge clk_i);
        sync_i <= 1'h0;
        run_len(0, 1'h0, n);
    endtask

    // ****
    // tests
    // ****
    initial begin
        logic [11:0] ix [0:11] = '{`OCD_IDX_DIV1_COUNTS, `OCD_IDX_DIV1_CTRL, `OCD_IDX_DIV1_ROUTE,
            `OCD_IDX_DIV2_COUNTS, `OCD_IDX_DIV2_CTRL, `OCD_IDX_DIV2_ROUTE, `OCD_IDX_S31_COUNTS,
            `OCD_IDX_S3_PHASE, `OCD_IDX_S32_COUNTS, `OCD_IDX_S3_BYPASS, `OCD_IDX_SRC_SEL, 12'h1f0};
        logic [7:0] rv [0:11] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h80, 8'h00, 8'h00, 8'h00, 8'h00,
            8'h00, 8'h00, 8'h00};
        logic [7:0] by [0:3] = '{8'h00, 8'h20, 8'h10, 8'h30};
        int eh [0:3] = '{48, 8, 16, 4};
        int el [0:3] = '{24, 16, 8, 4};
        logic [7:0] q;
        int n0, n, h, l;
        repeat (12) @(posedge clk_i);
        rst_i <= 1'h0;
        for (int i = 0; i < 12; i++) rchk(ix[i], rv[i]);
        wr(12'h1f0, 8'h5a);
        rchk(12'h1f0, 8'h00);
        wb(1'h1, `OCD_IDX_S3_PHASE, 8'h21, 4'h0, q);
        rchk(`OCD_IDX_S3_PHASE, 8'h00);
        wr(`OCD_IDX_S3_PHASE, 8'h21);
        rchk(`OCD_IDX_S3_PHASE, 8'h21);
        wr(`OCD_IDX_DIV2_ROUTE, 8'hff);
        rchk(`OCD_IDX_DIV2_ROUTE, 8'h03);
        wr(`OCD_IDX_DIV2_ROUTE, 8'h00);
        mchk(1, 4, 4);
        wr(`OCD_IDX_DIV2_CTRL, 8'h00);
        wr(`OCD_IDX_DIV2_COUNTS, 8'h20);
        mchk(1, 8, 24);
        wr(`OCD_IDX_DIV1_ROUTE, 8'h01);
        wr(`OCD_IDX_DIV1_COUNTS, 8'h12);
        mchk(0, 24, 16);
        wr(`OCD_IDX_DIV1_ROUTE, 8'h00);
        wr(`OCD_IDX_DIV1_COUNTS, 8'h13);
        mchk(0, 32, 16);
        wr(`OCD_IDX_DIV1_COUNTS, 8'h01);
        measure(0, h, l);
        chk_int(h + l, 24);
        chk_int(int'(h == 16), 0);
        wr(`OCD_IDX_DIV1_CTRL, 8'h80);
        mchk(0, 4, 4);
        mchk(1, 8, 24);
        wr(`OCD_IDX_DIV1_ROUTE, 8'h01);
        wr(`OCD_IDX_DIV1_COUNTS, 8'h10);
        wr(`OCD_IDX_DIV1_CTRL, 8'h20);
        sync_i <= 1'h1;
        repeat (10) @(posedge clk_i);
        run_len(0, 1'h1, n);
        chk_int(n, 600);
        wr(`OCD_IDX_DIV1_CTRL, 8'h00);
        repeat (10) @(posedge clk_i);
        run_len(0, 1'h0, n);
        chk_int(n, 600);
        wr(`OCD_IDX_DIV1_CTRL, 8'h40);
        mchk(0, 8, 16);
        sync_i <= 1'h0;
        t_start(8'h10, n0);
        t_start(8'h14, n);
        chk_int(n, n0 + 32);
        t_start(8'h00, n);
        chk_int(n, n0 + 16);
        wr(`OCD_IDX_DIV1_COUNTS, 8'h20);
        wr(`OCD_IDX_DIV1_ROUTE, 8'h03);
        mchk(0, 4, 4);
        mchk(1, 8, 24);
        wr(`OCD_IDX_SRC_SEL, 8'h01);
        mchk(0, 8, 24);
        wr(`OCD_IDX_SRC_SEL, 8'h02);
        mchk(0, 2, 2);
        wr(`OCD_IDX_SRC_SEL, 8'h00);
        wr(`OCD_IDX_S31_COUNTS, 8'h10);
        wr(`OCD_IDX_S32_COUNTS, 8'h01);
        wr(`OCD_IDX_S3_PHASE, 8'h00);
        for (int i = 0; i < 4; i++) begin
            wr(`OCD_IDX_S3_BYPASS, by[i]);
            mchk(2, eh[i], el[i]);
        end
        report_and_stop;
    end

    initial begin
        repeat (40000) @(posedge clk_i);
        miscompares++;
        report_and_stop;
    end
endmodule // ocd_top_test
